// ### core/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
	// ==========================================================
	// Widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 16;
	localparam int NCH    = 2;
	localparam int FLT_W  = 5;
	localparam int PSC_W  = 3;
	localparam int NSRC   = 6;

	// ==========================================================
	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SLAVE  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_OPTION = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_EVENT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_VALUE0 = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_VALUE1 = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_FLAG   = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_MISS   = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_IEN    = 8'h2c;

	// ==========================================================
	// Field positions.
	localparam int MODE_STRIDE = 16;
	localparam int EN_STRIDE   = 4;
	localparam int EN_BIT      = 0;
	localparam int POL_BIT     = 1;
	localparam int CH_LSB      = 1;

	// ==========================================================
	// Encodings.
	localparam logic [1:0] DIR_OUTPUT = 2'h0;
	localparam logic [1:0] DIR_OWN    = 2'h1;
	localparam logic [1:0] DIR_OTHER  = 2'h2;
	localparam logic [1:0] SRC_PCLK   = 2'h0;
	localparam logic [1:0] SRC_SLOW   = 2'h1;
	localparam logic [1:0] SRC_XTAL   = 2'h2;
	localparam logic [2:0] OCM_ACTIVE   = 3'h1;
	localparam logic [2:0] OCM_INACTIVE = 3'h2;
	localparam logic [2:0] OCM_TOGGLE   = 3'h3;
	localparam logic [2:0] OCM_LOW      = 3'h4;
	localparam logic [2:0] OCM_HIGH     = 3'h5;
	localparam logic [2:0] SMS_RESET    = 3'h4;
	localparam logic [2:0] TS_INPUT1    = 3'h5;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [FLT_W-1:0] FLT_ONE = 5'h01;
	localparam logic [PSC_W-1:0] PSC_ONE = 3'h1;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic [2:0] compare_mode_field;
		logic [3:0] input_filter_field;
		logic [1:0] input_prescale_field;
		logic [1:0] channel_direction_field;
	} tcc_chan_cfg_t;

	typedef struct packed {
		logic       trigger_polarity_bit;
		logic       ext_clock2_enable;
		logic [1:0] trigger_prescale_field;
		logic [3:0] trigger_filter_field;
		logic [2:0] trigger_select_field;
		logic [2:0] slave_mode_field;
	} tcc_slave_cfg_t;

	typedef struct packed {
		logic       clock_gate_enable;
		logic [1:0] trigger_source_select;
	} tcc_option_t;

	// ==========================================================
	// Shared decoding.
	function automatic logic [FLT_W-1:0] flt_len(input logic [3:0] f);
		case (f)
			4'h0: flt_len = 5'h01;
			4'h1: flt_len = 5'h02;
			4'h2: flt_len = 5'h04;
			4'h3: flt_len = 5'h08;
			default: flt_len = {f, 1'b0};
		endcase
	endfunction : flt_len

	function automatic logic [PSC_W-1:0] psc_max(input logic [1:0] f);
		case (f)
			2'h0: psc_max = 3'h0;
			2'h1: psc_max = 3'h1;
			2'h2: psc_max = 3'h3;
			default: psc_max = 3'h7;
		endcase
	endfunction : psc_max
endpackage : tcc_pkg
`default_nettype wire

// ### core/tcc_core.sv
// Overview of operation
// - Clock mode 2 counts external trigger edges.
// - Two-bit select picks the trigger source.
// - Pin source optionally ANDed with gate pin.
// - Trigger prescaler divides active edge count.
// - Trigger polarity zero means rising edges.
// - Trigger filter zero means no filtering.
// - Prescaled trigger resynchronised before counting.
// - Software reaches only the buffer register.
// - Capture via shadow; compare from shadow.
// - Input sampled, filtered, edge detected, prescaled.
// - Capture latches counter, sets flag, interrupts.
// - Capture over set flag sets missed flag.
// - Flag cleared by write-one or, in input role, value read.
// - Direction selects role; input makes read-only.
// - Filter 0011 needs eight equal samples.
// - Channel polarity selects rising or falling.
// - Prescale 00 captures on every active edge.
// - Captures only while channel enable set.
// - Software event bit raises channel flag.
// - Trigger 101, mode 100 resets counter.
// - Output equals reference xor polarity.
// - Modes 101/100 force reference high/low.
// - Comparison keeps flagging while forced.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcc_core (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// APB slave.
	input  wire logic [tcc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tcc_pkg::DATA_W-1:0]  pwdata,
	output logic      [tcc_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Clock sources and pins.
	input  wire logic                        osc_slow,
	input  wire logic                        osc_xtal,
	input  wire logic                        timer_clock_pin,
	input  wire logic                        clock_gate_pin,
	input  wire logic [tcc_pkg::NCH-1:0]     timer_input,
	// Channel outputs.
	output logic      [tcc_pkg::NCH-1:0]     channel_output,
	output logic      [tcc_pkg::NCH-1:0]     channel_output_enable,
	output logic                             irq_req
);
	// ==========================================================
	// Storage.
	logic [tcc_pkg::NSRC-1:0]    sync1_reg;
	logic [tcc_pkg::NSRC-1:0]    sync2_reg;
	logic                        pclk_div_reg;
	logic [2:0]                  flt_lvl_reg;
	logic [2:0]                  flt_prev_reg;
	logic [tcc_pkg::FLT_W-1:0]   flt_cnt_reg [3];
	logic [tcc_pkg::PSC_W-1:0]   psc_cnt_reg [3];
	logic                        etr_tick_reg;
	logic                        counter_run_bit;
	tcc_pkg::tcc_slave_cfg_t     slave_control_reg;
	tcc_pkg::tcc_option_t        option_reg;
	tcc_pkg::tcc_chan_cfg_t      cfg_reg [tcc_pkg::NCH];
	logic [tcc_pkg::NCH-1:0]     channel_enable_bit;
	logic [tcc_pkg::NCH-1:0]     channel_polarity_bit;
	logic [tcc_pkg::NCH-1:0]     interrupt_enable_reg;
	logic [tcc_pkg::CNT_W-1:0]   cnt_reg;
	logic [tcc_pkg::CNT_W-1:0]   channel_value_reg [tcc_pkg::NCH];
	logic [tcc_pkg::CNT_W-1:0]   shadow_reg [tcc_pkg::NCH];
	logic [tcc_pkg::NCH-1:0]     copy_pend_reg;
	logic [tcc_pkg::NCH-1:0]     channel_event_flag;
	logic [tcc_pkg::NCH-1:0]     missed_capture_flag;
	logic [tcc_pkg::NCH-1:0]     match_prev_reg;
	logic [tcc_pkg::NCH-1:0]     compare_reference_level;

	// ==========================================================
	// Bus decode.
	wire apb_setup  = psel & ~penable;
	wire apb_access = psel & penable;
	wire apb_wr     = apb_access & pwrite;
	wire apb_rd     = apb_access & ~pwrite;
	wire sel_ctrl   = paddr == tcc_pkg::OFF_CTRL;
	wire sel_slave  = paddr == tcc_pkg::OFF_SLAVE;
	wire sel_option = paddr == tcc_pkg::OFF_OPTION;
	wire sel_mode   = paddr == tcc_pkg::OFF_MODE;
	wire sel_enable = paddr == tcc_pkg::OFF_ENABLE;
	wire sel_event  = paddr == tcc_pkg::OFF_EVENT;
	wire sel_count  = paddr == tcc_pkg::OFF_COUNT;
	wire sel_flag   = paddr == tcc_pkg::OFF_FLAG;
	wire sel_miss   = paddr == tcc_pkg::OFF_MISS;
	wire sel_ien    = paddr == tcc_pkg::OFF_IEN;
	wire [tcc_pkg::NCH-1:0] sel_value = {paddr == tcc_pkg::OFF_VALUE1, paddr == tcc_pkg::OFF_VALUE0};
	wire sel_hit = sel_ctrl | sel_slave | sel_option | sel_mode | sel_enable | sel_event
		| sel_count | sel_flag | sel_miss | sel_ien | (|sel_value);

	logic [tcc_pkg::DATA_W-1:0] rd_mux;
	logic [tcc_pkg::DATA_W-1:0] mode_word;
	logic [tcc_pkg::DATA_W-1:0] enable_word;
	always_comb begin
		mode_word   = '0;
		enable_word = '0;
		for (int c = 0; c < tcc_pkg::NCH; c++) begin
			mode_word[c*tcc_pkg::MODE_STRIDE +: $bits(tcc_pkg::tcc_chan_cfg_t)] = cfg_reg[c];
			enable_word[c*tcc_pkg::EN_STRIDE + tcc_pkg::EN_BIT]  = channel_enable_bit[c];
			enable_word[c*tcc_pkg::EN_STRIDE + tcc_pkg::POL_BIT] = channel_polarity_bit[c];
		end
	end
	assign rd_mux = sel_ctrl   ? 32'(counter_run_bit) :
		sel_slave  ? 32'(slave_control_reg) :
		sel_option ? 32'(option_reg) :
		sel_mode   ? mode_word :
		sel_enable ? enable_word :
		sel_count  ? 32'(cnt_reg) :
		sel_value[0] ? 32'(channel_value_reg[0]) :
		sel_value[1] ? 32'(channel_value_reg[1]) :
		sel_flag   ? 32'({channel_event_flag, 1'b0}) :
		sel_miss   ? 32'({missed_capture_flag, 1'b0}) :
		sel_ien    ? 32'({interrupt_enable_reg, 1'b0}) : '0;

	// Read data is prepared in the setup cycle so the slave never waits.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= apb_setup ? rd_mux : prdata;
			pready  <= 1'b1;
			pslverr <= apb_setup & ~sel_hit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			counter_run_bit      <= 1'b0;
			slave_control_reg    <= '0;
			option_reg           <= '0;
			channel_enable_bit   <= '0;
			channel_polarity_bit <= '0;
			interrupt_enable_reg <= '0;
			for (int c = 0; c < tcc_pkg::NCH; c++) cfg_reg[c] <= '0;
		end else if (apb_wr) begin
			if (sel_ctrl) counter_run_bit <= pwdata[0];
			if (sel_slave) slave_control_reg <= pwdata[$bits(tcc_pkg::tcc_slave_cfg_t)-1:0];
			if (sel_option) option_reg <= pwdata[$bits(tcc_pkg::tcc_option_t)-1:0];
			if (sel_ien) interrupt_enable_reg <= pwdata[tcc_pkg::CH_LSB +: tcc_pkg::NCH];
			for (int c = 0; c < tcc_pkg::NCH; c++) begin
				if (sel_mode)
					cfg_reg[c] <= pwdata[c*tcc_pkg::MODE_STRIDE +: $bits(tcc_pkg::tcc_chan_cfg_t)];
				if (sel_enable) begin
					channel_enable_bit[c]   <= pwdata[c*tcc_pkg::EN_STRIDE + tcc_pkg::EN_BIT];
					channel_polarity_bit[c] <= pwdata[c*tcc_pkg::EN_STRIDE + tcc_pkg::POL_BIT];
				end
			end
		end
	end

	// ==========================================================
	// Pin synchronisers and trigger source.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg    <= '0;
			sync2_reg    <= '0;
			pclk_div_reg <= 1'b0;
		end else begin
			sync1_reg    <= {timer_input, clock_gate_pin, timer_clock_pin, osc_xtal, osc_slow};
			sync2_reg    <= sync1_reg;
			pclk_div_reg <= ~pclk_div_reg;
		end
	end

	wire gated_pin = sync2_reg[2] & (sync2_reg[3] | ~option_reg.clock_gate_enable);
	wire external_trigger_input =
		(option_reg.trigger_source_select == tcc_pkg::SRC_PCLK) ? pclk_div_reg :
		(option_reg.trigger_source_select == tcc_pkg::SRC_SLOW) ? sync2_reg[0] :
		(option_reg.trigger_source_select == tcc_pkg::SRC_XTAL) ? sync2_reg[1] : gated_pin;

	// ==========================================================
	// Digital filters: index 0 trigger, 1 and 2 the channel inputs.
	wire [2:0] flt_in = {sync2_reg[5], sync2_reg[4], external_trigger_input};
	wire [tcc_pkg::FLT_W-1:0] flt_need [3];
	assign flt_need[0] = tcc_pkg::flt_len(slave_control_reg.trigger_filter_field);
	assign flt_need[1] = tcc_pkg::flt_len(cfg_reg[0].input_filter_field);
	assign flt_need[2] = tcc_pkg::flt_len(cfg_reg[1].input_filter_field);

	// Level accepted after the programmed run of equal samples.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flt_lvl_reg  <= '0;
			flt_prev_reg <= '0;
			for (int i = 0; i < 3; i++) flt_cnt_reg[i] <= '0;
		end else begin
			flt_prev_reg <= flt_lvl_reg;
			for (int i = 0; i < 3; i++) begin
				if (flt_in[i] == flt_lvl_reg[i]) begin
					flt_cnt_reg[i] <= '0;
				end else if (flt_cnt_reg[i] == flt_need[i] - tcc_pkg::FLT_ONE) begin
					flt_lvl_reg[i] <= flt_in[i];
					flt_cnt_reg[i] <= '0;
				end else begin
					flt_cnt_reg[i] <= flt_cnt_reg[i] + tcc_pkg::FLT_ONE;
				end
			end
		end
	end
	wire [2:0] filtered_input = flt_lvl_reg;
	wire [2:0] rise = flt_lvl_reg & ~flt_prev_reg;
	wire [2:0] fall = ~flt_lvl_reg & flt_prev_reg;

	wire etr_edge = slave_control_reg.trigger_polarity_bit ? fall[0] : rise[0];
	// Channel edge polarity on its own input.
	wire [tcc_pkg::NCH-1:0] edge_detected_input;
	assign edge_detected_input[0] = channel_polarity_bit[0] ? fall[1] : rise[1];
	assign edge_detected_input[1] = channel_polarity_bit[1] ? fall[2] : rise[2];

	// Capture edge from the own or the neighbouring input.
	wire [tcc_pkg::NCH-1:0] capture_input_signal;
	assign capture_input_signal[0] = (cfg_reg[0].channel_direction_field == tcc_pkg::DIR_OTHER) ?
		(channel_polarity_bit[0] ? fall[2] : rise[2]) : edge_detected_input[0];
	assign capture_input_signal[1] = (cfg_reg[1].channel_direction_field == tcc_pkg::DIR_OTHER) ?
		(channel_polarity_bit[1] ? fall[1] : rise[1]) : edge_detected_input[1];

	// ==========================================================
	// Prescalers: index 0 trigger, 1 and 2 the channels.
	wire [2:0] psc_ev = {capture_input_signal, etr_edge};
	wire [tcc_pkg::PSC_W-1:0] psc_top [3];
	assign psc_top[0] = tcc_pkg::psc_max(slave_control_reg.trigger_prescale_field);
	assign psc_top[1] = tcc_pkg::psc_max(cfg_reg[0].input_prescale_field);
	assign psc_top[2] = tcc_pkg::psc_max(cfg_reg[1].input_prescale_field);
	wire [2:0] psc_hit;
	// One pulse per programmed number of edges.
	assign psc_hit[0] = psc_ev[0] & (psc_cnt_reg[0] == psc_top[0]);
	assign psc_hit[1] = psc_ev[1] & (psc_cnt_reg[1] == psc_top[1]);
	assign psc_hit[2] = psc_ev[2] & (psc_cnt_reg[2] == psc_top[2]);
	wire prescaled_trigger_signal = psc_hit[0];
	wire [tcc_pkg::NCH-1:0] prescaled_capture_signal = psc_hit[2:1];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 3; i++) psc_cnt_reg[i] <= '0;
		end else begin
			for (int i = 0; i < 3; i++)
				if (psc_ev[i]) psc_cnt_reg[i] <= psc_hit[i] ? '0 : psc_cnt_reg[i] + tcc_pkg::PSC_ONE;
		end
	end

	// ==========================================================
	// Counter.
	// Reset mode on channel one's filtered edge.
	wire slave_reset = (slave_control_reg.slave_mode_field == tcc_pkg::SMS_RESET)
		& (slave_control_reg.trigger_select_field == tcc_pkg::TS_INPUT1) & edge_detected_input[0];
	// External edges replace the internal clock.
	wire count_en = counter_run_bit & (~slave_control_reg.ext_clock2_enable | etr_tick_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			etr_tick_reg <= 1'b0;
			cnt_reg      <= '0;
		end else begin
			// Extra stage costs a cycle but keeps the count on the timer clock.
			etr_tick_reg <= prescaled_trigger_signal;
			if (apb_wr & sel_count) cnt_reg <= pwdata[tcc_pkg::CNT_W-1:0];
			else if (slave_reset) cnt_reg <= '0;
			else if (count_en) cnt_reg <= cnt_reg + tcc_pkg::CNT_ONE;
		end
	end

	// ==========================================================
	// Channels.
	for (genvar c = 0; c < tcc_pkg::NCH; c++) begin : g_ch
		wire is_input  = cfg_reg[c].channel_direction_field != tcc_pkg::DIR_OUTPUT;
		wire capture   = is_input & channel_enable_bit[c] & prescaled_capture_signal[c];
		wire match     = ~is_input & (cnt_reg == shadow_reg[c]);
		wire match_ev  = match & ~match_prev_reg[c];
		wire software_channel_event = apb_wr & sel_event & pwdata[tcc_pkg::CH_LSB + c];
		wire flag_set  = copy_pend_reg[c] | match_ev | software_channel_event;
		wire flag_clr  = (apb_wr & sel_flag & pwdata[tcc_pkg::CH_LSB + c])
			| (apb_rd & sel_value[c] & is_input);
		wire miss_set  = copy_pend_reg[c] & channel_event_flag[c];
		wire miss_clr  = apb_wr & sel_miss & pwdata[tcc_pkg::CH_LSB + c];
		logic ref_next;

		always_comb begin
			case (cfg_reg[c].compare_mode_field)
				tcc_pkg::OCM_ACTIVE:   ref_next = compare_reference_level[c] | match_ev;
				tcc_pkg::OCM_INACTIVE: ref_next = compare_reference_level[c] & ~match_ev;
				tcc_pkg::OCM_TOGGLE:   ref_next = compare_reference_level[c] ^ match_ev;
				tcc_pkg::OCM_LOW:      ref_next = 1'b0;
				tcc_pkg::OCM_HIGH:     ref_next = 1'b1;
				default:               ref_next = compare_reference_level[c];
			endcase
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				channel_value_reg[c]       <= '0;
				shadow_reg[c]              <= '0;
				copy_pend_reg[c]           <= 1'b0;
				match_prev_reg[c]          <= 1'b0;
				compare_reference_level[c] <= 1'b0;
			end else begin
				copy_pend_reg[c]  <= capture;
				match_prev_reg[c] <= match;
				compare_reference_level[c] <= ~is_input & ref_next;
				// Capture lands in the shadow, compare loads from the buffer.
				if (capture) shadow_reg[c] <= cnt_reg;
				else if (!is_input) shadow_reg[c] <= channel_value_reg[c];
				// Software writes the buffer only in output role.
				if (copy_pend_reg[c]) channel_value_reg[c] <= shadow_reg[c];
				else if (apb_wr & sel_value[c] & ~is_input) channel_value_reg[c] <= pwdata[tcc_pkg::CNT_W-1:0];
			end
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				channel_event_flag[c]  <= 1'b0;
				missed_capture_flag[c] <= 1'b0;
			end else begin
				channel_event_flag[c]  <= flag_set | (channel_event_flag[c] & ~flag_clr);
				missed_capture_flag[c] <= miss_set | (missed_capture_flag[c] & ~miss_clr);
			end
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				channel_output[c]        <= 1'b0;
				channel_output_enable[c] <= 1'b0;
			end else begin
				channel_output[c]        <= compare_reference_level[c] ^ channel_polarity_bit[c];
				channel_output_enable[c] <= ~is_input & channel_enable_bit[c];
			end
		end

		// ======================================================
		// Checks.
		sequence s_capture;
			capture ##1 copy_pend_reg[c];
		endsequence
		chk_capture_flag: assert property (@(posedge clk) disable iff (!reset_n)
			s_capture |=> channel_event_flag[c] && channel_value_reg[c] == $past(cnt_reg, 2))
			else $error("capture did not load buffer and flag");
		chk_missed_set: assert property (@(posedge clk) disable iff (!reset_n)
			copy_pend_reg[c] && channel_event_flag[c] |=> missed_capture_flag[c])
			else $error("missed capture not flagged");
		chk_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
			apb_rd && sel_value[c] && is_input && !copy_pend_reg[c] |=> !channel_event_flag[c])
			else $error("value read did not clear flag");
		chk_input_ro: assert property (@(posedge clk) disable iff (!reset_n)
			apb_wr && sel_value[c] && is_input && !copy_pend_reg[c] |=> $stable(channel_value_reg[c]))
			else $error("input channel value was written");
		chk_no_capture: assert property (@(posedge clk) disable iff (!reset_n)
			is_input && !channel_enable_bit[c] |=> !copy_pend_reg[c])
			else $error("capture while disabled");
		chk_sw_event: assert property (@(posedge clk) disable iff (!reset_n)
			software_channel_event |=> channel_event_flag[c])
			else $error("software event lost");
		chk_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
			flag_set && flag_clr |=> channel_event_flag[c])
			else $error("clear beat a set");
		chk_force_ref: assert property (@(posedge clk) disable iff (!reset_n)
			!is_input && cfg_reg[c].compare_mode_field == tcc_pkg::OCM_HIGH ##1
			!is_input && cfg_reg[c].compare_mode_field == tcc_pkg::OCM_LOW
			|-> compare_reference_level[c] ##1 !compare_reference_level[c])
			else $error("forced reference wrong");
		chk_out_pol: assert property (@(posedge clk) disable iff (!reset_n)
			##1 channel_output[c] == ($past(compare_reference_level[c]) ^ $past(channel_polarity_bit[c])))
			else $error("output polarity wrong");
		chk_force_flag: assert property (@(posedge clk) disable iff (!reset_n)
			match_ev && cfg_reg[c].compare_mode_field == tcc_pkg::OCM_HIGH |=> channel_event_flag[c])
			else $error("forced output lost compare flag");
	end

	chk_ext_count: assert property (@(posedge clk) disable iff (!reset_n)
		counter_run_bit && slave_control_reg.ext_clock2_enable && !etr_tick_reg
		&& !(apb_wr && sel_count) && !slave_reset |=> $stable(cnt_reg))
		else $error("counter moved without trigger tick");
	chk_trig_resync: assert property (@(posedge clk) disable iff (!reset_n)
		prescaled_trigger_signal |=> etr_tick_reg)
		else $error("trigger tick not resynchronised");
	chk_gate_pin: assert property (@(posedge clk) disable iff (!reset_n)
		option_reg.trigger_source_select == 2'h3 && option_reg.clock_gate_enable && !sync2_reg[3]
		|-> !external_trigger_input)
		else $error("gate pin did not mask clock pin");
	chk_filter8: assert property (@(posedge clk) disable iff (!reset_n)
		cfg_reg[0].input_filter_field == 4'h3 && flt_in[1] != flt_lvl_reg[1] && flt_cnt_reg[1] == 5'h07
		|=> $changed(flt_lvl_reg[1]))
		else $error("filter did not accept after eight samples");
	chk_slave_reset: assert property (@(posedge clk) disable iff (!reset_n)
		slave_reset && !(apb_wr && sel_count) |=> cnt_reg == '0)
		else $error("trigger did not reset counter");

	// ==========================================================
	// Interrupt request.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) irq_req <= 1'b0;
		else irq_req <= |(channel_event_flag & interrupt_enable_reg);
	end
endmodule : tcc_core
`default_nettype wire

// ### tb/tcc_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
	// Bench control.
	input  wire logic       clk,
	input  wire logic [3:0] pulses,
	input  wire logic       go,
	// Pin.
	output logic            timer_clock_pin
);
	logic [5:0] left = 6'h0;
	// The pin clock stands low between bursts, as a gated source would.
	assign timer_clock_pin = left[1];
	always @(posedge clk) left <= go ? {pulses, 2'h0} : left - 6'(left != 6'h0);
endmodule : tcc_pins
`default_nettype wire

// ### tb/timer_capture_compare_channels_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_channels_tb;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq_req, go, err, tclk, gate;
	logic [31:0] pwdata, prdata, r;
	logic [7:0]  paddr;
	logic [3:0]  pulses;
	logic [1:0]  want_in, cho, choe;
	int          num_errors = 0, n_compared = 0, cycles = 0;
	tcc_core i_tcc_core (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_slow(1'b0), .osc_xtal(1'b0), .timer_clock_pin(tclk), .clock_gate_pin(gate),
		.timer_input(want_in), .channel_output(cho), .channel_output_enable(choe), .irq_req(irq_req));
	tcc_pins i_tcc_pins (.clk(clk), .pulses(pulses), .go(go), .timer_clock_pin(tclk));
	initial begin clk = 1'b0; forever #10 clk = ~clk; end
	always @(posedge clk) cycles <= cycles + 1;
	always @(posedge clk) if (cycles == 20000) begin num_errors++; conclude(); end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin num_errors++; $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp); end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{r, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	task automatic pin(input logic [1:0] v, input int n);
		want_in <= v;
		repeat (n) @(posedge clk);
	endtask : pin
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, want_in, pulses, go, gate} = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, 8'h3c, 32'h0);
		chk({r[31:1], err}, 32'h1);
		apb(1'b1, tcc_pkg::OFF_MODE, 32'h0000_0031);
		apb(1'b1, tcc_pkg::OFF_ENABLE, 32'h1);
		apb(1'b1, tcc_pkg::OFF_IEN, 32'h6);
		apb(1'b1, tcc_pkg::OFF_COUNT, 32'h1234);
		apb(1'b1, tcc_pkg::OFF_FLAG, 32'h6);
		pin(2'h1, 4);
		pin(2'h0, 24);
		pin(2'h1, 24);
		rd(tcc_pkg::OFF_FLAG, 32'h2);
		rd(tcc_pkg::OFF_MISS, 32'h0);
		rd(tcc_pkg::OFF_VALUE0, 32'h1234);
		pin(2'h0, 24);
		rd(tcc_pkg::OFF_FLAG, 32'h0);
		pin(2'h1, 24);
		apb(1'b1, tcc_pkg::OFF_ENABLE, 32'h3);
		pin(2'h0, 24);
		rd(tcc_pkg::OFF_MISS, 32'h2);
		apb(1'b1, tcc_pkg::OFF_EVENT, 32'h4);
		rd(tcc_pkg::OFF_FLAG, 32'h6);
		chk(irq_req, 1'b1);
		apb(1'b1, tcc_pkg::OFF_FLAG, 32'h6);
		apb(1'b1, tcc_pkg::OFF_MODE, 32'h0500_0031);
		apb(1'b1, tcc_pkg::OFF_ENABLE, 32'h10);
		apb(1'b1, tcc_pkg::OFF_COUNT, 32'h10);
		chk({cho[1], choe[1]}, 2'h3);
		apb(1'b1, tcc_pkg::OFF_VALUE1, 32'h10);
		// The match flag needs two cycles; the disabled channel 0 sees a rise meanwhile.
		pin(2'h1, 24);
		rd(tcc_pkg::OFF_FLAG, 32'h4);
		pin(2'h0, 24);
		apb(1'b1, tcc_pkg::OFF_OPTION, 32'h7);
		apb(1'b1, tcc_pkg::OFF_SLAVE, 32'h1400);
		apb(1'b1, tcc_pkg::OFF_CTRL, 32'h1);
		// The first burst is masked by the gate pin, the second one counts.
		for (int k = 0; k < 2; k++) begin
			{pulses, go, gate} <= {4'h6, 1'b1, 1'(k)};
			@(posedge clk);
			go <= 1'b0;
			repeat (40) @(posedge clk);
			rd(tcc_pkg::OFF_COUNT, k ? 32'h13 : 32'h10);
		end
		apb(1'b1, tcc_pkg::OFF_MODE, 32'h0400_0031);
		repeat (3) @(posedge clk);
		chk({cho[1], choe[1]}, 2'h1);
		apb(1'b1, tcc_pkg::OFF_ENABLE, 32'h30);
		repeat (2) @(posedge clk);
		chk({cho[1], choe[1]}, 2'h3);
		// Period capture: channel 1 rises and resets the counter, channel 2 takes the fall.
		apb(1'b1, tcc_pkg::OFF_SLAVE, 32'h2c);
		apb(1'b1, tcc_pkg::OFF_MODE, 32'h0002_0001);
		apb(1'b1, tcc_pkg::OFF_ENABLE, 32'h31);
		pin(2'h1, 24);
		pin(2'h0, 24);
		rd(tcc_pkg::OFF_VALUE1, 32'h17);
		conclude();
	end
endmodule : timer_capture_compare_channels_tb
`default_nettype wire
